/* File: dv/pcg_top_chk.sv */
`timescale 1ns/100ps
// ------------------
// apb and gate checks
// ------------------
module pcg_chk (
   input wire logic                          pclk,
   input wire logic                          presetn,
   input wire logic                          psel,
   input wire logic                          penable,
   input wire logic                          pwrite,
   input wire logic [pcg_pkg::ADDR_W-1:0]    paddr,
   input wire logic [pcg_pkg::DATA_W-1:0]    pwdata,
   input wire logic [3:0]                    pstrb,
   input wire logic [pcg_pkg::DATA_W-1:0]    prdata,
   input wire logic                          pready,
   input wire logic                          pslverr,
   input wire pcg_pkg::pcg_clk_en_t          clk_en,
   input wire logic [pcg_pkg::NUM_GATES-1:0] gated_clk
);
   localparam logic [15:0] A0 = pcg_pkg::ADDR_TIMER;
   localparam logic [15:0] A1 = pcg_pkg::ADDR_SERIAL;
   localparam logic [15:0] A2 = pcg_pkg::ADDR_MISC;
   localparam logic [15:0] A3 = pcg_pkg::ADDR_EXT_IRQ;
   logic        mapped;
   logic [15:0] wa;
   logic [31:0] wd_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign mapped = paddr inside {A0, A1, A2, A3};
   // zero when no committing write, so no register matches
   assign wa = (pready && pwrite && mapped && pstrb[0]) ? paddr : 16'h0000;
   always_ff @(posedge pclk) wd_q <= pwdata;
   property p_gate;
      @(negedge pclk) disable iff (!presetn) gated_clk == $past(clk_en);
   endproperty
   chk_zero_wait: assert property (psel && !penable ##1 psel && penable |-> pready)
      else $error("access cycle without ready");
   chk_reset_off: assert property ($rose(presetn) |-> clk_en == '0)
      else $error("enables not clear after reset");
   chk_timer_bits: assert property (wa == A0 |=> clk_en[3:0] == {wd_q[5:4], wd_q[1:0]})
      else $error("timer enables wrong");
   chk_serial_bits: assert property (wa == A1 |=> clk_en[6:4] == {wd_q[4], wd_q[1:0]})
      else $error("serial enables wrong");
   chk_misc_bits: assert property (wa == A2 |=> clk_en[8:7] == {wd_q[4], wd_q[0]})
      else $error("misc enables wrong");
   chk_irq_bits: assert property (wa == A3 |=> clk_en[14:9] == wd_q[5:0])
      else $error("interrupt enables wrong");
   chk_unmapped: assert property (pready && !mapped |-> pslverr && prdata == '0)
      else $error("unmapped access not refused");
   chk_gate_follow: assert property (p_gate)
      else $error("gated clock does not follow enable");
   cover property (wa == A3);
   cover property (pready && pslverr);
   cover property (pready && !pwrite && prdata != '0);
endmodule
bind pcg_top pcg_chk u_pcg_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .clk_en(clk_en), .gated_clk(gated_clk)
);

/* File: dv/testbench.sv */
`timescale 1ns/100ps
// --------------
// register bench
// --------------
module testbench;
   logic                 pclk = 1'b0;
   logic                 presetn = 1'b0;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [15:0]          paddr = 16'h0000;
   logic [31:0]          pwdata = 32'h0000_0000;
   logic [3:0]           pstrb = 4'h0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   pcg_pkg::pcg_clk_en_t clk_en;
   logic [14:0]          gclk;
   logic [14:0]          gprev = 15'h0000;
   logic [7:0]           mdl [4];
   int                   gcnt [15];
   logic [31:0]          rd;
   logic                 er;
   int                   fail_count = 0;
   int                   tests_run = 0;
   logic [15:0]          amap [6] = '{pcg_pkg::ADDR_TIMER, pcg_pkg::ADDR_SERIAL,
      pcg_pkg::ADDR_MISC, pcg_pkg::ADDR_EXT_IRQ, 16'h3DCC, 16'h3DE0};

   always #4 pclk = ~pclk;

   // counted in one process, so no per-bit race
   always @(gclk) begin
      for (int i = 0; i < 15; i++) gcnt[i] += (gclk[i] === 1'b1 && gprev[i] !== 1'b1);
      gprev = gclk;
   end

   pcg_top u_pcg_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .clk_en(clk_en), .gated_clk(gclk)
   );

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // sampled right at the edge: the values that stood just before it
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            chk(32'h0, 32'h1, "no ready");
            tally_and_finish();
         end
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [14:0] exp_en();
      return {mdl[3][5:0], mdl[2][4], mdl[2][0], mdl[1][4], mdl[1][1:0], mdl[0][5:4],
              mdl[0][1:0]};
   endfunction

   task automatic check_all();
      logic [14:0] e;
      e = exp_en();
      for (int r = 0; r < 6; r++) begin
         apb(1'b0, amap[r], 32'h0, 4'h0);
         chk(rd, r < 4 ? {24'h0, mdl[r]} : 32'h0, "read data");
         chk(er, r > 3, "read error");
      end
      chk(clk_en, e, "enables");
      @(negedge pclk);
      foreach (gcnt[i]) gcnt[i] = 0;
      repeat (8) @(posedge pclk);
      @(negedge pclk);
      for (int g = 0; g < 15; g++) chk(gcnt[g], e[g] ? 8 : 0, "edges");
   endtask

   initial begin
      logic [31:0] d;
      logic [3:0]  s;
      int          k;
      void'($urandom(32'haa67));
      foreach (mdl[r]) mdl[r] = 8'h00;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      check_all();
      $display("test reset done");
      for (int i = 0; i < 40; i++) begin
         k = (i < 6) ? i : $urandom_range(5, 0);
         d = (i < 6) ? 32'hFFFF_FFFF : $urandom;
         s = (i < 6) ? 4'hF : 4'($urandom);
         // nothing hangs off the gates, so clearing a bit never stops a busy unit
         apb(1'b1, amap[k], d, s);
         chk(er, k > 3, "write error");
         if (k < 4 && s[0]) mdl[k] = d[7:0];
         if (i % 4 == 3) check_all();
      end
      $display("test random writes done");
      apb(1'b1, amap[0], 32'h0000_00FF, 4'h1);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (mdl[r]) mdl[r] = 8'h00;
      check_all();
      $display("test second reset done");
      tally_and_finish();
   end
endmodule

/* File: rtl/pcg_clk_gate.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// glitch-free clock gate
// ---------------------------------------------------------------------------
module pcg_clk_gate (
   input  wire logic clk,
   input  wire logic en,
   output wire logic gclk
);

   logic en_l;

   // enable only moves while clk is low, so no pulse is ever cut short
   always_latch begin
      if (!clk) begin
         en_l = en;
      end
   end

   assign gclk = clk & en_l;

endmodule

/* File: rtl/pcg_pkg.sv */
// ---------------------------------------------------------------------------
// peripheral clock gating: shared constants and types
// ---------------------------------------------------------------------------
package pcg_pkg;

   // ------------------------------------------------------------------------
   // bus and register geometry
   // ------------------------------------------------------------------------
   localparam int unsigned ADDR_W    = 16;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned REG_W     = 8;
   localparam int unsigned NUM_REGS  = 4;
   localparam int unsigned NUM_GATES = 15;

   // printed offsets are register indices; the byte address is four times each
   localparam logic [11:0] IDX_TIMER   = 12'hF74;
   localparam logic [11:0] IDX_SERIAL  = 12'hF75;
   localparam logic [11:0] IDX_MISC    = 12'hF76;
   localparam logic [11:0] IDX_EXT_IRQ = 12'hF77;

   localparam logic [ADDR_W-1:0] ADDR_TIMER   = {2'h0, IDX_TIMER, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_SERIAL  = {2'h0, IDX_SERIAL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_MISC    = {2'h0, IDX_MISC, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_EXT_IRQ = {2'h0, IDX_EXT_IRQ, 2'h0};

   // slot order inside the register file
   localparam int unsigned SLOT_TIMER   = 0;
   localparam int unsigned SLOT_SERIAL  = 1;
   localparam int unsigned SLOT_MISC    = 2;
   localparam int unsigned SLOT_EXT_IRQ = 3;

   localparam logic [ADDR_W-1:0] REG_ADDR [NUM_REGS] = '{
      ADDR_TIMER, ADDR_SERIAL, ADDR_MISC, ADDR_EXT_IRQ
   };

   localparam logic [REG_W-1:0] REG_RST = 8'h00;

   // ------------------------------------------------------------------------
   // enable bit positions
   // ------------------------------------------------------------------------
   localparam int unsigned BIT_TIMER_PAIR_B   = 5;
   localparam int unsigned BIT_TIMER_PAIR_A   = 4;
   localparam int unsigned BIT_CAPTURE_ONE    = 1;
   localparam int unsigned BIT_CAPTURE_ZERO   = 0;
   localparam int unsigned BIT_TWO_WIRE       = 4;
   localparam int unsigned BIT_ASYNC_PORT_B   = 1;
   localparam int unsigned BIT_ASYNC_PORT_A   = 0;
   localparam int unsigned BIT_CALENDAR       = 4;
   localparam int unsigned BIT_SYNC_SERIAL    = 0;
   localparam int unsigned BIT_EXT_IRQ_BASE   = 0;

   // gate g is driven by bit GATE_BIT[g] of register slot GATE_REG[g]
   localparam int unsigned GATE_REG [NUM_GATES] = '{
      SLOT_TIMER, SLOT_TIMER, SLOT_TIMER, SLOT_TIMER,
      SLOT_SERIAL, SLOT_SERIAL, SLOT_SERIAL,
      SLOT_MISC, SLOT_MISC,
      SLOT_EXT_IRQ, SLOT_EXT_IRQ, SLOT_EXT_IRQ,
      SLOT_EXT_IRQ, SLOT_EXT_IRQ, SLOT_EXT_IRQ
   };
   localparam int unsigned GATE_BIT [NUM_GATES] = '{
      BIT_CAPTURE_ZERO, BIT_CAPTURE_ONE, BIT_TIMER_PAIR_A, BIT_TIMER_PAIR_B,
      BIT_ASYNC_PORT_A, BIT_ASYNC_PORT_B, BIT_TWO_WIRE,
      BIT_SYNC_SERIAL, BIT_CALENDAR,
      BIT_EXT_IRQ_BASE, BIT_EXT_IRQ_BASE + 1, BIT_EXT_IRQ_BASE + 2,
      BIT_EXT_IRQ_BASE + 3, BIT_EXT_IRQ_BASE + 4, BIT_EXT_IRQ_BASE + 5
   };

   // ------------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------------
   // field order matches the gate index order, gate 0 in the lsb
   typedef struct packed {
      logic [5:0] ext_irq_clk_en;
      logic       calendar_clk_en;
      logic       sync_serial_clk_en;
      logic       two_wire_clk_en;
      logic       async_port_b_clk_en;
      logic       async_port_a_clk_en;
      logic       timer_pair_b_clk_en;
      logic       timer_pair_a_clk_en;
      logic       capture_timer_one_clk_en;
      logic       capture_timer_zero_clk_en;
   } pcg_clk_en_t;

   typedef enum logic {
      PCG_ST_IDLE,
      PCG_ST_ACK
   } pcg_apb_st_t;

endpackage

/* File: rtl/pcg_top.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------------------
// peripheral clock gating, apb slave
// ---------------------------------------------------------------------------
// Operation
// - a gating bit at 0 stops that peripheral's clock.
// - a gating bit at 1 runs that peripheral's clock.
// - all gating registers clear to zero on reset; all clocks stopped.
// - timer register: bit5 pair b, bit4 pair a, bit1/bit0 capture timers.
// - serial register: bit4 two-wire, bit1 async port b, bit0 port a.
// - misc register: calendar and synchronous serial enables, eight bits rw.
// - external interrupt register: inputs zero to five in bits 0 to 5.
module pcg_top (
   input  wire logic                                  pclk,
   input  wire logic                                  presetn,
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [pcg_pkg::ADDR_W-1:0]            paddr,
   input  wire logic [pcg_pkg::DATA_W-1:0]            pwdata,
   input  wire logic [3:0]                            pstrb,
   output logic      [pcg_pkg::DATA_W-1:0]            prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   output pcg_pkg::pcg_clk_en_t                       clk_en,
   output wire logic [pcg_pkg::NUM_GATES-1:0]         gated_clk
);

   // ------------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------------
   logic [pcg_pkg::REG_W-1:0]     regs_q [pcg_pkg::NUM_REGS];
   logic [pcg_pkg::REG_W-1:0]     regs_d [pcg_pkg::NUM_REGS];
   logic                          addr_hit;
   logic [1:0]                    addr_idx;
   pcg_pkg::pcg_apb_st_t          st_q;
   pcg_pkg::pcg_apb_st_t          st_d;
   logic                          err_q;
   logic                          err_d;
   logic [pcg_pkg::DATA_W-1:0]    rdata_q;
   logic [pcg_pkg::DATA_W-1:0]    rdata_d;
   logic                          access;
   logic                          wr_en;
   logic [pcg_pkg::NUM_GATES-1:0] gate_en;

   // ------------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------------
   // only the four gating words answer; every other address, reserved or
   // not, is refused with pslverr and leaves the registers untouched
   always_comb begin
      addr_hit = 1'b0;
      addr_idx = 2'h0;
      for (int i = 0; i < pcg_pkg::NUM_REGS; i++) begin
         if (paddr == pcg_pkg::REG_ADDR[i]) begin
            addr_hit = 1'b1;
            addr_idx = 2'(i);
         end
      end
   end

   // ------------------------------------------------------------------------
   // apb handshake
   // ------------------------------------------------------------------------
   // decode and read data are caught in the setup cycle so that prdata
   // comes from a flop; the access phase then completes with no wait state
   always_comb begin
      st_d    = st_q;
      err_d   = err_q;
      rdata_d = rdata_q;
      unique case (st_q)
         pcg_pkg::PCG_ST_IDLE: begin
            if (psel && !penable) begin
               st_d  = pcg_pkg::PCG_ST_ACK;
               err_d = !addr_hit;
               if (addr_hit && !pwrite) begin
                  rdata_d = {{(pcg_pkg::DATA_W - pcg_pkg::REG_W){1'b0}}, regs_q[addr_idx]};
               end else begin
                  rdata_d = '0;
               end
            end
         end
         pcg_pkg::PCG_ST_ACK: begin
            // a master that drops psel early simply abandons the transfer
            if (!psel || penable) begin
               st_d = pcg_pkg::PCG_ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q    <= pcg_pkg::PCG_ST_IDLE;
         err_q   <= 1'b0;
         rdata_q <= '0;
      end else begin
         st_q    <= st_d;
         err_q   <= err_d;
         rdata_q <= rdata_d;
      end
   end

   assign access  = (st_q == pcg_pkg::PCG_ST_ACK) && psel && penable;
   assign pready  = access;
   assign pslverr = access && err_q;
   assign prdata  = rdata_q;

   // ------------------------------------------------------------------------
   // gating registers
   // ------------------------------------------------------------------------
   // byte-wide registers sit in lane 0; a write without pstrb[0] is taken
   // on the bus but changes nothing
   assign wr_en = access && pwrite && !err_q && pstrb[0];

   always_comb begin
      for (int i = 0; i < pcg_pkg::NUM_REGS; i++) begin
         regs_d[i] = regs_q[i];
         if (wr_en && (addr_idx == 2'(i))) begin
            // all eight bits of every gating register are read/write
            regs_d[i] = pwdata[pcg_pkg::REG_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < pcg_pkg::NUM_REGS; i++) begin
            regs_q[i] <= pcg_pkg::REG_RST;
         end
      end else begin
         for (int i = 0; i < pcg_pkg::NUM_REGS; i++) begin
            regs_q[i] <= regs_d[i];
         end
      end
   end

   // ------------------------------------------------------------------------
   // clock gates
   // ------------------------------------------------------------------------
   // the basic clock is pclk itself; each gate follows its own enable bit
   // on the next low phase, so a change lands at the next rising edge
   generate
      for (genvar g = 0; g < pcg_pkg::NUM_GATES; g++) begin : g_gate
         assign gate_en[g] = regs_q[pcg_pkg::GATE_REG[g]][pcg_pkg::GATE_BIT[g]];

         pcg_clk_gate u_gate (
            .clk  (pclk),
            .en   (gate_en[g]),
            .gclk (gated_clk[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------------------
   // level enables
   // ------------------------------------------------------------------------
   // for peripherals that also need to know they are powered, e.g. to hold
   // their outputs quiet; stopping a busy peripheral is left to software
   assign clk_en = pcg_pkg::pcg_clk_en_t'(gate_en);

endmodule
